// >>> verilog/shcmp_pkg.sv
`default_nettype none
package shcmp_pkg;

  // ----------------------------------------------------------------
  // Major opcodes, bits 15..11 of a halfword
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_PREFIX = 5'h1e;
  localparam logic [4:0] OP_REG_REG = 5'h1d;
  localparam logic [4:0] OP_SHIFT = 5'h06;
  localparam logic [4:0] OP_STORE_HALF = 5'h19;
  localparam logic [4:0] OP_CMP_S_IMM = 5'h0a;
  localparam logic [4:0] OP_CMP_U_IMM = 5'h0b;

  // ----------------------------------------------------------------
  // Register-register functions, bits 4..0, and the convert selector, bits 7..5
  // ----------------------------------------------------------------
  localparam logic [4:0] FN_CONVERT = 5'h11;
  localparam logic [4:0] FN_CMP_S_REG = 5'h02;
  localparam logic [4:0] FN_CMP_U_REG = 5'h03;
  localparam logic [4:0] FN_SHIFT_VAR = 5'h04;
  localparam logic [2:0] CNV_SEL_HALF = 3'h5;

  // ----------------------------------------------------------------
  // Shift functions, bits 1..0, and short-form amounts
  // ----------------------------------------------------------------
  localparam logic [1:0] SH_LEFT = 2'h0;
  localparam logic [1:0] SH_ARITH = 2'h3;
  localparam logic [4:0] SHORT_ZERO_AMT = 5'h08;

  // ----------------------------------------------------------------
  // Registers and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] RESULT_GPR = 5'h18;
  localparam logic [4:0] XLAT_LOW_BASE = 5'h10;
  localparam logic [31:0] GPR_RESET = 32'h0;
  localparam logic [15:0] HALF_RESET = 16'h0;

  // ----------------------------------------------------------------
  // Exception codes on the exception port
  // ----------------------------------------------------------------
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_ADDR = 3'h1;
  localparam logic [2:0] EXC_TLB_REFILL = 3'h2;
  localparam logic [2:0] EXC_TLB_INVALID = 3'h3;
  localparam logic [2:0] EXC_TLB_MOD = 3'h4;
  localparam logic [2:0] EXC_BUS = 3'h5;

  typedef enum {ST_IDLE, ST_WAIT} state_type;

endpackage
`default_nettype wire

// >>> verilog/shcmp_exec.sv
// Overview of operation
// - Halfword sign-extend replaces the register with its low 16 bits sign-extended.
// - Short halfword store address is base plus offset times two, stores low halfword.
// - Prefixed halfword store adds the sign-extended 16-bit unscaled offset to base.
// - Odd store address raises address error and no store is made.
// - Store reports TLB refill, invalid, modified, bus and address errors.
// - Short left shift by the 3-bit amount with zero fill into destination.
// - Short fixed shifts treat amount zero as eight, range one to eight.
// - Prefixed left shift uses a 5-bit amount from the prefix, zero to 31.
// - Variable left shift shifts second register by first register's low five bits.
// - Register signed compare writes 1 or 0 into register 24.
// - Short signed immediate compare uses zero-extended 8-bit immediate, result in 24.
// - Prefixed signed immediate compare uses sign-extended 16-bit immediate.
// - Short unsigned immediate compare uses zero-extended 8-bit immediate.
// - Prefixed unsigned compare sign-extends immediate then compares unsigned.
// - Register unsigned compare writes 1 or 0 into register 24.
// - Short arithmetic right shift replicates the sign bit into vacated bits.
`timescale 1ns/1ps
`default_nettype none
module shcmp_exec
  import shcmp_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Instruction halfwords from the pipeline
  input wire logic HW_VALID_IN,
  input wire logic [15:0] HW_DATA_IN,
  output logic READY_OUT,
  // Retirement and exceptions
  output logic DONE_OUT,
  output logic EXC_VALID_OUT,
  output logic [2:0] EXC_CODE_OUT,
  // Register file load and observe port
  input wire logic GPR_WR_EN_IN,
  input wire logic [4:0] GPR_WR_IDX_IN,
  input wire logic [31:0] GPR_WR_DATA_IN,
  input wire logic [4:0] GPR_RD_IDX_IN,
  output logic [31:0] GPR_RD_DATA_OUT,
  // Halfword store to the translation and memory path
  output logic ST_REQ_OUT,
  output logic [31:0] ST_ADDR_OUT,
  output logic [15:0] ST_DATA_OUT,
  input wire logic ST_DONE_IN,
  input wire logic MEM_TLB_REFILL_IN,
  input wire logic MEM_TLB_INVALID_IN,
  input wire logic MEM_TLB_MOD_IN,
  input wire logic MEM_BUS_ERR_IN
);

  // ----------------------------------------------------------------
  // Register file and helpers
  // ----------------------------------------------------------------
  logic [31:0] gpr_r [32];

  // Compressed field to architectural register
  function automatic logic [4:0] xlat(input logic [2:0] f);
    xlat = (f < 3'h2) ? (XLAT_LOW_BASE | {4'h0, f[0]}) : {2'b00, f};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  state_type state_r, state_nxt;
  logic pfx_valid_r, pfx_valid_nxt;
  logic [15:0] pfx_r, pfx_nxt;
  logic [4:0] major, funct, rx_idx, ry_idx, amt_short, amt;
  logic [15:0] imm16;
  logic [31:0] rx_val, ry_val, sh_addr;
  logic take, ext;

  // Fields of the current halfword and its prefix
  assign take = (state_r == ST_IDLE) && HW_VALID_IN;
  assign major = HW_DATA_IN[15:11];
  assign funct = HW_DATA_IN[4:0];
  assign ext = pfx_valid_r;
  assign rx_idx = xlat(HW_DATA_IN[10:8]);
  assign ry_idx = xlat(HW_DATA_IN[7:5]);
  assign rx_val = gpr_r[rx_idx];
  assign ry_val = gpr_r[ry_idx];
  assign imm16 = {pfx_r[4:0], pfx_r[10:5], HW_DATA_IN[4:0]};
  // Zero in the short field means eight
  assign amt_short = (HW_DATA_IN[4:2] == 3'h0) ? SHORT_ZERO_AMT
                   : {2'b00, HW_DATA_IN[4:2]};
  assign amt = ext ? pfx_r[10:6] : amt_short;
  // Prefixed offset is unscaled, short offset counts halfwords
  assign sh_addr = ext ? rx_val + sext16(imm16)
                 : rx_val + {26'h0, HW_DATA_IN[4:0], 1'b0};

  // ----------------------------------------------------------------
  // Execute: next state, register write, store and events
  // ----------------------------------------------------------------
  logic wr_en;
  logic [4:0] wr_idx;
  logic [31:0] wr_data, rd_nxt, st_addr_nxt;
  logic [15:0] st_data_nxt;
  logic st_req_r, st_req_nxt, done_r, done_nxt, exc_r, exc_nxt, ready_r;
  logic [2:0] exc_code_r, exc_code_nxt;

  // Only 32-bit wraparound arithmetic here, so nothing can overflow
  always_comb
  begin
    state_nxt = state_r;
    pfx_valid_nxt = pfx_valid_r;
    pfx_nxt = pfx_r;
    wr_en = 1'b0;
    wr_idx = RESULT_GPR;
    wr_data = GPR_RESET;
    st_req_nxt = st_req_r;
    st_addr_nxt = ST_ADDR_OUT;
    st_data_nxt = ST_DATA_OUT;
    done_nxt = 1'b0;
    exc_nxt = 1'b0;
    exc_code_nxt = EXC_CODE_OUT;
    case (state_r)
      ST_IDLE:
      begin
        if (take && major == OP_PREFIX && !pfx_valid_r)
        begin
          // Held until its instruction arrives
          pfx_valid_nxt = 1'b1;
          pfx_nxt = HW_DATA_IN;
        end
        else if (take)
        begin
          pfx_valid_nxt = 1'b0;
          done_nxt = 1'b1;
          case (major)
            OP_REG_REG:
            begin
              wr_en = 1'b1;
              if (funct == FN_CONVERT && HW_DATA_IN[7:5] == CNV_SEL_HALF)
              begin
                wr_idx = rx_idx;
                wr_data = sext16(rx_val[15:0]);
              end
              else if (funct == FN_CMP_S_REG)
                wr_data = {31'h0, $signed(rx_val) < $signed(ry_val)};
              else if (funct == FN_CMP_U_REG)
                wr_data = {31'h0, rx_val < ry_val};
              else if (funct == FN_SHIFT_VAR)
              begin
                wr_idx = ry_idx;
                wr_data = ry_val << rx_val[4:0];
              end
              else
                wr_en = 1'b0;
            end
            OP_SHIFT:
            begin
              wr_idx = rx_idx;
              if (HW_DATA_IN[1:0] == SH_LEFT)
              begin
                wr_en = 1'b1;
                wr_data = ry_val << amt;
              end
              else if (HW_DATA_IN[1:0] == SH_ARITH)
              begin
                wr_en = 1'b1;
                wr_data = $signed(ry_val) >>> amt;
              end
            end
            OP_CMP_S_IMM:
            begin
              wr_en = 1'b1;
              if (ext)
                wr_data = {31'h0, $signed(rx_val) < $signed(sext16(imm16))};
              else
                wr_data = {31'h0, $signed(rx_val) < $signed({24'h0, HW_DATA_IN[7:0]})};
            end
            OP_CMP_U_IMM:
            begin
              wr_en = 1'b1;
              if (ext)
                wr_data = {31'h0, rx_val < sext16(imm16)};
              else
                wr_data = {31'h0, rx_val < {24'h0, HW_DATA_IN[7:0]}};
            end
            OP_STORE_HALF:
            begin
              done_nxt = 1'b0;
              if (sh_addr[0])
              begin
                // Odd address never reaches memory
                exc_nxt = 1'b1;
                exc_code_nxt = EXC_ADDR;
              end
              else
              begin
                st_req_nxt = 1'b1;
                st_addr_nxt = sh_addr;
                st_data_nxt = ry_val[15:0];
                state_nxt = ST_WAIT;
              end
            end
            default:
            begin
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        if (ST_DONE_IN)
        begin
          st_req_nxt = 1'b0;
          state_nxt = ST_IDLE;
          // Translation faults outrank a bus error
          exc_nxt = 1'b1;
          if (MEM_TLB_REFILL_IN)
            exc_code_nxt = EXC_TLB_REFILL;
          else if (MEM_TLB_INVALID_IN)
            exc_code_nxt = EXC_TLB_INVALID;
          else if (MEM_TLB_MOD_IN)
            exc_code_nxt = EXC_TLB_MOD;
          else if (MEM_BUS_ERR_IN)
            exc_code_nxt = EXC_BUS;
          else
          begin
            exc_nxt = 1'b0;
            done_nxt = 1'b1;
          end
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    rd_nxt = (GPR_RD_IDX_IN == 5'h0) ? GPR_RESET : gpr_r[GPR_RD_IDX_IN];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control state; a pipeline write drops any load in the same cycle, whatever its slot
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      state_r <= ST_IDLE;
      pfx_valid_r <= 1'b0;
      pfx_r <= HALF_RESET;
      st_req_r <= 1'b0;
      ST_ADDR_OUT <= GPR_RESET;
      ST_DATA_OUT <= HALF_RESET;
      done_r <= 1'b0;
      exc_r <= 1'b0;
      exc_code_r <= EXC_NONE;
      ready_r <= 1'b0;
      GPR_RD_DATA_OUT <= GPR_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      pfx_valid_r <= pfx_valid_nxt;
      pfx_r <= pfx_nxt;
      st_req_r <= st_req_nxt;
      ST_ADDR_OUT <= st_addr_nxt;
      ST_DATA_OUT <= st_data_nxt;
      done_r <= done_nxt;
      exc_r <= exc_nxt;
      exc_code_r <= exc_code_nxt;
      ready_r <= (state_nxt == ST_IDLE);
      GPR_RD_DATA_OUT <= rd_nxt;
    end
  end

  // Register file; slot zero always reads as zero
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      for (int i = 0; i < 32; i++)
        gpr_r[i] <= GPR_RESET;
    end
    else if (wr_en && wr_idx != 5'h0)
      gpr_r[wr_idx] <= wr_data;
    else if (GPR_WR_EN_IN && GPR_WR_IDX_IN != 5'h0)
      gpr_r[GPR_WR_IDX_IN] <= GPR_WR_DATA_IN;
  end

  assign READY_OUT = ready_r;
  assign ST_REQ_OUT = st_req_r;
  assign DONE_OUT = done_r;
  assign EXC_VALID_OUT = exc_r;
  assign EXC_CODE_OUT = exc_code_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_store_even_addr: assert property (ST_REQ_OUT |-> !ST_ADDR_OUT[0])
    else $error("store issued at odd address");
  a_odd_addr_error: assert property (take && !pfx_valid_r && major == OP_STORE_HALF
      && sh_addr[0] |=> EXC_VALID_OUT && EXC_CODE_OUT == EXC_ADDR && !ST_REQ_OUT)
    else $error("odd store address not refused");
  a_store_held: assert property (ST_REQ_OUT && !ST_DONE_IN |=> ST_REQ_OUT
      && $stable(ST_ADDR_OUT) && $stable(ST_DATA_OUT))
    else $error("store request dropped before done");
  a_bus_error_out: assert property (ST_REQ_OUT && ST_DONE_IN && MEM_BUS_ERR_IN
      && !MEM_TLB_REFILL_IN && !MEM_TLB_INVALID_IN && !MEM_TLB_MOD_IN
      |=> EXC_VALID_OUT && EXC_CODE_OUT == EXC_BUS && !DONE_OUT)
    else $error("bus error not reported");
  a_prefix_joins: assert property (take && major == OP_PREFIX && !pfx_valid_r
      |=> pfx_valid_r && !DONE_OUT && !EXC_VALID_OUT)
    else $error("prefix retired on its own");
  a_short_zero_eight: assert property (take && !pfx_valid_r && major == OP_SHIFT
      && HW_DATA_IN[4:0] == 5'h0
      |=> gpr_r[$past(rx_idx)] == {$past(ry_val[23:0]), 8'h0})
    else $error("short shift by zero not eight");
  a_unsigned_imm: assert property (take && !pfx_valid_r && major == OP_CMP_U_IMM
      |=> gpr_r[RESULT_GPR][31:1] == 31'h0
      && gpr_r[RESULT_GPR][0] == ($past(rx_val) < {24'h0, $past(HW_DATA_IN[7:0])}))
    else $error("unsigned immediate compare wrong");
  a_signed_reg: assert property (take && !pfx_valid_r && major == OP_REG_REG
      && funct == FN_CMP_S_REG
      |=> gpr_r[RESULT_GPR] == {31'h0, $signed($past(rx_val)) < $signed($past(ry_val))})
    else $error("signed register compare wrong");
  a_wait_not_ready: assert property (state_r == ST_WAIT |-> !READY_OUT ##0 ST_REQ_OUT)
    else $error("ready while store pending");

endmodule
`default_nettype wire

// >>> tb/mem_path_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Memory path stand-in answering halfword stores
// ----------------------------------------------------------------
module mem_path_model
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Store request from the block
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic [15:0] data_in,
  // Bench control: wait cycles and fault flags to report
  input wire logic [3:0] delay_in,
  input wire logic [3:0] fault_in,
  // Answer to the block
  output logic done_out,
  output logic [3:0] flags_out,
  // Last store taken, and how many were taken
  output logic [31:0] last_addr_out,
  output logic [15:0] last_data_out,
  output logic [15:0] count_out
);
  logic [3:0] wait_r;

  // Flags only mean something beside done, so between answers they
  // toggle each cycle rather than hold a value the block might trust
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      done_out <= 1'b0;
      wait_r <= 4'h0;
      count_out <= 16'h0;
      flags_out <= 4'h5;
    end
    else if (req_in && done_out)
    begin
      done_out <= 1'b0;
      wait_r <= 4'h0;
      last_addr_out <= addr_in;
      last_data_out <= data_in;
      count_out <= count_out + 16'h1;
      flags_out <= ~flags_out;
    end
    else if (req_in && wait_r >= delay_in)
    begin
      done_out <= 1'b1;
      flags_out <= fault_in;
    end
    else
    begin
      wait_r <= req_in ? wait_r + 4'h1 : 4'h0;
      flags_out <= ~flags_out;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import shcmp_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hw_valid = 1'b0;
  logic [15:0] hw_data = 16'h0;
  logic wr_en = 1'b0;
  logic [4:0] wr_idx = 5'h0;
  logic [31:0] wr_data = 32'h0;
  logic [4:0] rd_idx = 5'h0;
  logic [3:0] delay = 4'h0;
  logic [3:0] fault = 4'h0;
  wire logic ready, done, exc_valid, st_req, st_done;
  wire logic [2:0] exc_code;
  wire logic [31:0] rd_data, st_addr, last_addr;
  wire logic [15:0] st_data, last_data, st_count;
  wire logic [3:0] flags;
  logic [31:0] gpr [0:31];
  logic [31:0] rv;
  logic [3:0] ft [0:7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'h0, 4'h0};
  logic [2:0] ct [0:7] = '{EXC_NONE, EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_TLB_MOD,
                           EXC_BUS, EXC_TLB_REFILL, EXC_ADDR, EXC_ADDR};
  integer seed = 3372;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  shcmp_exec uut (.CLK_IN(clk), .SRST_IN(srst), .HW_VALID_IN(hw_valid), .HW_DATA_IN(hw_data),
    .READY_OUT(ready), .DONE_OUT(done), .EXC_VALID_OUT(exc_valid), .EXC_CODE_OUT(exc_code),
    .GPR_WR_EN_IN(wr_en), .GPR_WR_IDX_IN(wr_idx), .GPR_WR_DATA_IN(wr_data),
    .GPR_RD_IDX_IN(rd_idx), .GPR_RD_DATA_OUT(rd_data), .ST_REQ_OUT(st_req),
    .ST_ADDR_OUT(st_addr), .ST_DATA_OUT(st_data), .ST_DONE_IN(st_done),
    .MEM_TLB_REFILL_IN(flags[0]), .MEM_TLB_INVALID_IN(flags[1]),
    .MEM_TLB_MOD_IN(flags[2]), .MEM_BUS_ERR_IN(flags[3]));

  mem_path_model mem (.clk_in(clk), .srst_in(srst), .req_in(st_req), .addr_in(st_addr),
    .data_in(st_data), .delay_in(delay), .fault_in(fault), .done_out(st_done),
    .flags_out(flags), .last_addr_out(last_addr), .last_data_out(last_data),
    .count_out(st_count));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] xl(input logic [2:0] r);
    xl = (r < 3'h2) ? 5'h10 + {4'h0, r[0]} : {2'h0, r};
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Holds the halfword up until an edge sees ready high
  task put(input logic [15:0] hw);
    int k;
    k = 0;
    hw_valid <= 1'b1;
    hw_data <= hw;
    @(posedge clk);
    while (ready !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task retire(output logic [2:0] code);
    int k;
    k = 0;
    hw_valid <= 1'b0;
    @(posedge clk);
    while (done !== 1'b1 && exc_valid !== 1'b1 && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    // A pulse that never came yields a code that no answer uses
    code = (done === 1'b1) ? EXC_NONE : (exc_valid === 1'b1) ? exc_code : 3'h7;
  endtask

  task peek(input logic [4:0] idx);
    rd_idx <= idx;
    @(posedge clk);
    @(posedge clk);
    rv = rd_data;
  endtask

  // Random compressed registers, half of them small so compares land close
  task rnd_regs;
    logic [31:0] v;
    for (int r = 0; r < 8; r++)
    begin
      v = $random(seed);
      if (v[0])
        v = {{24{v[31]}}, v[7:0]};
      gpr[xl(r[2:0])] = v;
    end
    gpr[24] = $random(seed) | 32'h1;
  endtask

  task load_all;
    for (int r = 0; r < 9; r++)
    begin
      wr_en <= 1'b1;
      wr_idx <= (r == 8) ? 5'h18 : xl(r[2:0]);
      wr_data <= (r == 8) ? gpr[24] : gpr[xl(r[2:0])];
      @(posedge clk);
    end
    wr_en <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    logic [2:0] rx, ry, s3, c;
    logic [15:0] im, pre, hw;
    logic [31:0] a, b, e, off;
    logic [4:0] d;
    int n;
    logic [15:0] n0;
    foreach (gpr[r])
      gpr[r] = 32'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    peek(5'h05);
    chk(rv, GPR_RESET);
    // Every computational kind, amount zero first pass for the short shifts;
    // late arithmetic shifts take the prefixed form
    for (int i = 0; i < 44; i++)
    begin
      rnd_regs();
      off = $random(seed);
      {rx, ry, s3, im} = off[24:0];
      if (i < 11)
        s3 = 3'h0;
      n = (s3 == 3'h0) ? 8 : s3;
      a = gpr[xl(rx)];
      b = gpr[xl(ry)];
      pre = 16'h0;
      d = RESULT_GPR;
      case (i % 11)
        0: {hw, d, e} = {OP_REG_REG, rx, CNV_SEL_HALF, FN_CONVERT, xl(rx), {{16{a[15]}}, a[15:0]}};
        1: {hw, d, e} = {OP_SHIFT, rx, ry, s3, SH_LEFT, xl(rx), b << n};
        2: {pre, hw, d, e} = {(i < 22) ? 16'h0 : {OP_PREFIX, im[4:0], 6'h0}, OP_SHIFT, rx, ry,
                              (i < 22) ? s3 : 3'h0, SH_ARITH, xl(rx),
                              32'($signed(b) >>> ((i < 22) ? n : int'(im[4:0])))};
        3: {pre, hw, d, e} = {OP_PREFIX, im[4:0], 6'h0, OP_SHIFT, rx, ry, 3'h0, SH_LEFT,
                              xl(rx), b << im[4:0]};
        4: {hw, d, e} = {OP_REG_REG, rx, ry, FN_SHIFT_VAR, xl(ry), b << a[4:0]};
        5: {hw, e} = {OP_REG_REG, rx, ry, FN_CMP_S_REG, 31'h0, $signed(a) < $signed(b)};
        6: {hw, e} = {OP_REG_REG, rx, ry, FN_CMP_U_REG, 31'h0, a < b};
        7: {hw, e} = {OP_CMP_S_IMM, rx, im[7:0], 31'h0,
                      $signed(a) < $signed({24'h0, im[7:0]})};
        8: {pre, hw, e} = {OP_PREFIX, im[10:5], im[15:11], OP_CMP_S_IMM, rx, 3'h0, im[4:0],
                           31'h0, $signed(a) < $signed({{16{im[15]}}, im})};
        9: {hw, e} = {OP_CMP_U_IMM, rx, im[7:0], 31'h0, a < {24'h0, im[7:0]}};
        default: {pre, hw, e} = {OP_PREFIX, im[10:5], im[15:11], OP_CMP_U_IMM, rx, 3'h0,
                                 im[4:0], 31'h0, a < {{16{im[15]}}, im}};
      endcase
      load_all();
      if (pre != 16'h0)
        put(pre);
      put(hw);
      retire(c);
      chk({29'h0, c}, {29'h0, EXC_NONE});
      gpr[d] = e;
      peek(d);
      chk(rv, e);
    end
    // Halfword stores in both forms, every fault kind, then odd addresses
    for (int j = 0; j < 8; j++)
    begin
      rnd_regs();
      a = $random(seed);
      {rx, ry, im} = a[21:0];
      off = j[0] ? {{16{im[15]}}, im} : {26'h0, im[4:0], 1'b0};
      e = gpr[xl(rx)] + off;
      if (e[0] != (j >= 6))
        gpr[xl(rx)][0] = ~gpr[xl(rx)][0];
      e = gpr[xl(rx)] + off;
      load_all();
      a = $random(seed);
      fault <= ft[j];
      delay <= {1'b0, a[2:0]};
      n0 = st_count;
      if (j[0])
        put({OP_PREFIX, im[10:5], im[15:11]});
      put({OP_STORE_HALF, rx, ry, im[4:0]});
      retire(c);
      chk({29'h0, c}, {29'h0, ct[j]});
      chk({16'h0, st_count}, {16'h0, n0 + ((j >= 6) ? 16'h0 : 16'h1)});
      if (j < 6)
      begin
        chk(last_addr, e);
        chk({16'h0, last_data}, {16'h0, gpr[xl(ry)][15:0]});
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
